// ### rtl/sr_params.svh
// Timing, threshold and ramp constants for the rectifier sequencer
`ifndef SR_PARAMS_SVH
`define SR_PARAMS_SVH

`define SR_CLK_MHZ        200
`define SR_NS_PER_US      1000
`define SR_DT_SCALE_PF    3
`define SR_RD_MIN_K       20
`define SR_RD_MAX_K       100
`define SR_NODE_ONE_V     12'h400
`define SR_CHARGE_STEP    3'h1
`define SR_STOP_STEP      3'h3
`define SR_HICCUP_STEP    3'h6
`define SR_CHARGE_DIV     64
`define SR_WIDTH_SHIFT    4

`endif

// ### rtl/sr_pkg.sv
// State types for the rectifier sequencer
package sr_pkg;

    typedef enum logic [1:0] {
        PH_LEAD,
        PH_POWER,
        PH_FREE
    } phase_state_t;

    typedef enum logic [1:0] {
        ND_HOLD,
        ND_CHARGE,
        ND_STOP,
        ND_DONE
    } node_state_t;

endpackage

// ### rtl/sr_ramp.sv
// Rectifier soft-start node modelled as a rate-divided up/down counter
`timescale 1ns/1ps
`include "sr_params.svh"

module sr_ramp #(
    parameter int W   = 12,
    parameter int DIV = `SR_CHARGE_DIV
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         clear,
    input  wire logic         charge,
    input  wire logic         discharge,
    input  wire logic [2:0]   down_step,
    output logic      [W-1:0] level
);

    logic [15:0] div_cnt;
    logic        tick;

    assign tick = (div_cnt == 16'h0000);

    // Shared divider keeps charge and discharge rates in exact ratio
    always_ff @(posedge ref_clk) begin
        if (rst || tick) begin
            div_cnt <= 16'(DIV - 1);
        end else begin
            div_cnt <= div_cnt - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
            level <= '0;
        end else if (tick && discharge) begin
            if (level > W'(down_step)) begin
                level <= level - W'(down_step);
            end else begin
                level <= '0;
            end
        end else if (tick && charge && level != {W{1'b1}}) begin
            level <= level + W'(`SR_CHARGE_STEP);
        end
    end

endmodule

// ### rtl/sync_rectifier_sequencer.sv
// Bridge phase sequencing with synchronous rectifier dead-times and soft-start
//
// Behaviour
// R1: Bridge runs diagonal A, all-off, diagonal B, all-off in turn.
// R2: During diagonal A power, rectifier A on and rectifier B off.
// R3: During diagonal B power, rectifier B on and rectifier A off.
// R4: In steady freewheeling both rectifiers are on.
// R5: Out-of-phase rectifier drops a leading dead-time before the next diagonal.
// R6: Other rectifier returns a trailing dead-time after the primary pulse ends.
// R7: Each dead-time is set resistance times 3 pF, resistance held to 20k..100k.
// R8: After power-up the rectifier soft-start node stays discharged.
// R9: Rectifiers stay off throughout primary soft-start.
// R10: Node released only with primary soft-start above 2 V and error current low.
// R11: Node charges steadily; rectifier soft-start begins past 1 V.
// R12: Soft-start pulses both rectifiers in freewheel, leading edge moving earlier.
// R13: At clock edge ending freewheel, in-phase stays on and other goes off.
// R14: In soft-start the in-phase rectifier ends together with the primary pulse.
// R15: Node forced low outside disables both rectifiers.
// R16: Line in standby band soft-stops, ramping node down at three times.
// R17: Node down to 1 V discharges both soft-start nodes; primary held till then.
// R18: Hiccup runs the same soft-stop at six times the charging rate.
// R19: Overvoltage, supply, reference or thermal faults drive all bridge and rectifier outputs low.
// R20: Soft-stop disable turns every fault into a hard-stop.
// R21: Thermal shutdown discharges both nodes, then normal restart after cooling.
// R22: Analog comparisons arrive as flags; capacitor ramps are counters.
`timescale 1ns/1ps
`include "sr_params.svh"

module sync_rectifier_sequencer #(
    parameter int NODE_W = 12,
    parameter int CNT_W  = 16,
    parameter int DIV    = `SR_CHARGE_DIV
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              osc_pulse,
    input  wire logic              pwm_stop,
    input  wire logic [6:0]        leading_deadtime_set,
    input  wire logic [6:0]        trailing_deadtime_set,
    input  wire logic              ss_above_2v,
    input  wire logic              comp_current_low,
    input  wire logic              line_standby,
    input  wire logic              line_shutdown,
    input  wire logic              hiccup_request,
    input  wire logic              line_overvoltage_fault,
    input  wire logic              vcc_undervoltage,
    input  wire logic              ref_undervoltage,
    input  wire logic              thermal_limit,
    input  wire logic              soft_stop_disable,
    input  wire logic              node_forced_low,
    output logic                   bridge_a_high,
    output logic                   bridge_a_low,
    output logic                   bridge_b_high,
    output logic                   bridge_b_low,
    output logic                   rectifier_a_drive,
    output logic                   rectifier_b_drive,
    output logic                   primary_ss_discharge,
    output logic [NODE_W-1:0]      rectifier_softstart_node,
    output logic                   rectifier_softstart_active
);

    localparam logic [NODE_W-1:0] ONE_V = NODE_W'(`SR_NODE_ONE_V);
    localparam logic [NODE_W-1:0] FULL  = {NODE_W{1'b1}};

    sr_pkg::phase_state_t ph_state;
    sr_pkg::node_state_t  node_state;
    logic                 phase_b;
    logic [CNT_W-1:0]     dt_cnt;
    logic [CNT_W-1:0]     elapsed;
    logic [CNT_W-1:0]     last_half;
    logic [CNT_W-1:0]     lead_cycles;
    logic [CNT_W-1:0]     trail_cycles;
    logic [CNT_W-1:0]     remaining;
    logic [CNT_W-1:0]     pulse_width;
    logic [NODE_W-1:0]    level;
    logic                 hard_fault;
    logic                 soft_fault;
    logic                 run;
    logic                 ramp_on;
    logic                 steady;
    logic                 trail_done;
    logic                 node_clear;
    logic                 node_at_floor;
    logic [2:0]           down_step;
    logic                 next_rect_a;
    logic                 next_rect_b;

    // Dead-time in ns is kOhm times pF; rounded up to whole clock cycles
    function automatic logic [CNT_W-1:0] dt_cycles(input logic [6:0] r);
        int rk;
        int ns;
        rk = int'(r);
        if (rk < `SR_RD_MIN_K) begin
            rk = `SR_RD_MIN_K;
        end
        if (rk > `SR_RD_MAX_K) begin
            rk = `SR_RD_MAX_K;
        end
        ns = rk * `SR_DT_SCALE_PF;
        return CNT_W'((ns * `SR_CLK_MHZ + `SR_NS_PER_US - 1) / `SR_NS_PER_US);
    endfunction

    assign lead_cycles  = dt_cycles(leading_deadtime_set);   // R7
    assign trail_cycles = dt_cycles(trailing_deadtime_set);  // R7

    // Fault classes from synchronised comparator flags
    assign hard_fault = line_overvoltage_fault | vcc_undervoltage | ref_undervoltage
                      | thermal_limit | line_shutdown
                      | (soft_stop_disable & (line_standby | hiccup_request)); // R19 R20 R22
    assign soft_fault = ~soft_stop_disable & (line_standby | hiccup_request);  // R16 R18

    assign down_step     = hiccup_request ? `SR_HICCUP_STEP : `SR_STOP_STEP; // R16 R18
    assign node_at_floor = (level <= ONE_V);
    assign node_clear    = (node_state == sr_pkg::ND_HOLD)
                        || (node_state == sr_pkg::ND_DONE)
                        || node_forced_low;                 // R8 R15

    sr_ramp #(
        .W   (NODE_W),
        .DIV (DIV)
    ) u_ramp (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .clear     (node_clear),
        .charge    (node_state == sr_pkg::ND_CHARGE),     // R11
        .discharge (node_state == sr_pkg::ND_STOP),
        .down_step (down_step),
        .level     (level)
    );

    // Node sequencing: release, charge, soft-stop, full discharge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            node_state <= sr_pkg::ND_HOLD;                  // R8
        end else begin
            unique case (node_state)
                sr_pkg::ND_HOLD: begin
                    if (!hard_fault && !soft_fault && !node_forced_low
                        && ss_above_2v && comp_current_low) begin
                        node_state <= sr_pkg::ND_CHARGE;    // R10
                    end
                end
                sr_pkg::ND_CHARGE: begin
                    if (hard_fault) begin
                        node_state <= sr_pkg::ND_DONE;      // R19
                    end else if (soft_fault) begin
                        node_state <= sr_pkg::ND_STOP;      // R16 R18
                    end else if (node_forced_low) begin
                        node_state <= sr_pkg::ND_HOLD;      // R15
                    end
                end
                sr_pkg::ND_STOP: begin
                    if (hard_fault || node_at_floor) begin
                        node_state <= sr_pkg::ND_DONE;      // R17
                    end
                end
                sr_pkg::ND_DONE: begin
                    // Restart only once every fault has cleared
                    if (!hard_fault && !soft_fault) begin
                        node_state <= sr_pkg::ND_HOLD;      // R21
                    end
                end
            endcase
        end
    end

    // Primary soft-start held high during soft-stop until node reaches floor
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            primary_ss_discharge <= 1'b1;
        end else begin
            primary_ss_discharge <= hard_fault
                || (node_state == sr_pkg::ND_DONE)
                || (node_state == sr_pkg::ND_STOP && node_at_floor); // R17 R21
        end
    end

    assign run = !hard_fault && (node_state != sr_pkg::ND_DONE);

    // Half-period measurement for leading-edge placement
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            elapsed   <= '0;
            last_half <= '0;
        end else if (osc_pulse) begin
            elapsed   <= '0;
            last_half <= elapsed + CNT_W'(1);
        end else if (elapsed != {CNT_W{1'b1}}) begin
            elapsed <= elapsed + CNT_W'(1);
        end
    end

    // Bridge phase sequence; oscillator edge always starts a new half-cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ph_state <= sr_pkg::PH_FREE;
            phase_b  <= 1'b1;
            dt_cnt   <= '0;
        end else if (osc_pulse) begin
            phase_b  <= ~phase_b;                           // R1
            ph_state <= sr_pkg::PH_LEAD;
            dt_cnt   <= lead_cycles - CNT_W'(1);            // R5
        end else begin
            unique case (ph_state)
                sr_pkg::PH_LEAD: begin
                    if (dt_cnt == '0) begin
                        ph_state <= sr_pkg::PH_POWER;
                    end else begin
                        dt_cnt <= dt_cnt - CNT_W'(1);
                    end
                end
                sr_pkg::PH_POWER: begin
                    if (pwm_stop) begin
                        ph_state <= sr_pkg::PH_FREE;
                        // Full count: bridges drop one edge later, so gap starts there
                        dt_cnt   <= trail_cycles;           // R6
                    end
                end
                sr_pkg::PH_FREE: begin
                    if (dt_cnt != '0) begin
                        dt_cnt <= dt_cnt - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    assign trail_done = (ph_state == sr_pkg::PH_FREE) && (dt_cnt == '0);

    // Bridges drive only after lead dead-time, so it eats primary on-time
    always_ff @(posedge ref_clk) begin
        if (rst || !run || ph_state != sr_pkg::PH_POWER || osc_pulse) begin
            bridge_a_high <= 1'b0;                          // R19
            bridge_b_low  <= 1'b0;
            bridge_b_high <= 1'b0;
            bridge_a_low  <= 1'b0;
        end else begin
            bridge_a_high <= !phase_b;                      // R1
            bridge_b_low  <= !phase_b;
            bridge_b_high <= phase_b;
            bridge_a_low  <= phase_b;
        end
    end

    assign ramp_on     = (node_state == sr_pkg::ND_CHARGE || node_state == sr_pkg::ND_STOP)
                      && (level > ONE_V) && !node_forced_low;          // R11 R15
    assign steady      = (node_state == sr_pkg::ND_CHARGE) && (level == FULL);
    assign pulse_width = CNT_W'((level - ONE_V) >> `SR_WIDTH_SHIFT);
    assign remaining   = (last_half > elapsed) ? (last_half - elapsed) : '0;

    // Rectifier drive; osc_pulse deasserts the out-of-phase side at once
    always_comb begin
        next_rect_a = 1'b0;
        next_rect_b = 1'b0;
        if (hard_fault || !ramp_on || osc_pulse) begin
            next_rect_a = 1'b0;                             // R9 R15 R19
            next_rect_b = 1'b0;
        end else if (ph_state != sr_pkg::PH_FREE) begin
            next_rect_a = !phase_b;                         // R2 R5 R13
            next_rect_b = phase_b;                          // R3 R5 R13
        end else if (steady) begin
            next_rect_a = !phase_b || trail_done;           // R4 R6
            next_rect_b = phase_b || trail_done;            // R4 R6
        end else begin
            // Narrow pulse ends at the clock edge; width grows with the node
            next_rect_a = (remaining <= pulse_width);       // R12 R14
            next_rect_b = (remaining <= pulse_width);       // R12 R14
        end
    end

    // In-phase rectifier keeps its level through the osc edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rectifier_a_drive <= 1'b0;                      // R8
            rectifier_b_drive <= 1'b0;
        end else if (osc_pulse && !hard_fault && ramp_on) begin
            rectifier_a_drive <= rectifier_a_drive && phase_b;  // R13
            rectifier_b_drive <= rectifier_b_drive && !phase_b; // R13
        end else begin
            rectifier_a_drive <= next_rect_a;
            rectifier_b_drive <= next_rect_b;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rectifier_softstart_node   <= '0;
            rectifier_softstart_active <= 1'b0;
        end else begin
            rectifier_softstart_node   <= level;            // R22
            rectifier_softstart_active <= ramp_on && !steady;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    hard_stop_a: assert property (hard_fault |=> !bridge_a_high && !bridge_b_high
        && !bridge_a_low && !bridge_b_low && !rectifier_a_drive && !rectifier_b_drive) // R19
        else $error("outputs not low after hard fault");

    diag_pair_a: assert property (bridge_a_high == bridge_b_low
        && bridge_b_high == bridge_a_low && !(bridge_a_high && bridge_b_high)) // R1
        else $error("bridge diagonal mismatch");

    power_a_rect_a: assert property (ph_state == sr_pkg::PH_POWER && !phase_b
        && ramp_on && !hard_fault && !osc_pulse |=> rectifier_a_drive && !rectifier_b_drive) // R2
        else $error("rectifiers wrong in A power");

    power_b_rect_a: assert property (ph_state == sr_pkg::PH_POWER && phase_b
        && ramp_on && !hard_fault && !osc_pulse |=> rectifier_b_drive && !rectifier_a_drive) // R3
        else $error("rectifiers wrong in B power");

    freewheel_both_a: assert property (trail_done && steady && !hard_fault
        && !osc_pulse && !node_forced_low |=> rectifier_a_drive && rectifier_b_drive) // R4
        else $error("rectifiers not both on in freewheel");

    lead_gap_a: assert property (osc_pulse && run |=> !bridge_a_high && !bridge_b_high
        ##1 (!bridge_a_high && !bridge_b_high)) // R5
        else $error("bridge on inside leading dead-time");

    hold_release_a: assert property (node_state == sr_pkg::ND_HOLD
        && !(ss_above_2v && comp_current_low) |=> node_state == sr_pkg::ND_HOLD) // R10
        else $error("node released without conditions");

    below_one_v_a: assert property (level <= ONE_V && !osc_pulse
        |=> !rectifier_a_drive && !rectifier_b_drive) // R9
        else $error("rectifier on below 1 V");

    forced_low_a: assert property (node_forced_low
        |=> !rectifier_a_drive && !rectifier_b_drive) // R15
        else $error("rectifier on while node forced low");

    stop_floor_a: assert property (node_state == sr_pkg::ND_STOP && node_at_floor
        |=> primary_ss_discharge ##1 node_state == sr_pkg::ND_DONE) // R17
        else $error("no discharge at 1 V floor");

    cover_steady_c: cover property (steady && trail_done);
    cover_softstop_c: cover property (node_state == sr_pkg::ND_STOP
        ##[1:1000] node_state == sr_pkg::ND_DONE);
    cover_ss_pulse_c: cover property (!steady && ramp_on
        && ph_state == sr_pkg::PH_FREE && next_rect_a);
    cover_hard_c: cover property (node_state == sr_pkg::ND_CHARGE && hard_fault);

endmodule

// ### verif/rect_gate_model.sv
// Secondary-side rectifier gate drivers seen across the isolation barrier
`timescale 1ns/1ps

module rect_gate_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic rectifier_a_drive,
    input  wire logic rectifier_b_drive,
    input  wire logic ground_request,
    output logic      node_forced_low,
    output logic      gate_a,
    output logic      gate_b
);
    // Outside party grounding the rectifier node, passed straight through
    assign node_forced_low = ground_request;

    // One cycle of isolator delay; gates follow the controls, never ahead
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gate_a <= 1'b0;
            gate_b <= 1'b0;
        end else begin
            gate_a <= rectifier_a_drive;
            gate_b <= rectifier_b_drive;
        end
    end
endmodule

// ### verif/sync_rectifier_sequencer_tb_top.sv
// Directed testbench for the rectifier sequencer
`timescale 1ns/1ps

module sync_rectifier_sequencer_tb_top;
    localparam int LEAD  = 12;  // 10k setting clamps up to 20k
    localparam int TRAIL = 24;  // 40k setting
    localparam int PER   = 200;
    localparam int ON    = 80;
    logic        ref_clk, rst, osc_pulse, pwm_stop, ss_above_2v, comp_current_low;
    logic        line_standby, hiccup_request, soft_stop_disable, ground_request;
    logic [4:0]  hard;  // shutdown, overvoltage, vcc, reference, thermal
    logic        bah, bal, bbh, bbl, ra, rb, pss, active, forced_low;
    logic [11:0] node;
    int          fails, num_checks, cyc, rel;
    bit          half_a;

    sync_rectifier_sequencer #(.DIV(1)) DUT (
        .ref_clk(ref_clk), .rst(rst), .osc_pulse(osc_pulse), .pwm_stop(pwm_stop),
        .leading_deadtime_set(7'h0a), .trailing_deadtime_set(7'h28),
        .ss_above_2v(ss_above_2v), .comp_current_low(comp_current_low),
        .line_standby(line_standby), .line_shutdown(hard[4]),
        .hiccup_request(hiccup_request), .line_overvoltage_fault(hard[3]),
        .vcc_undervoltage(hard[2]), .ref_undervoltage(hard[1]), .thermal_limit(hard[0]),
        .soft_stop_disable(soft_stop_disable), .node_forced_low(forced_low),
        .bridge_a_high(bah), .bridge_a_low(bal), .bridge_b_high(bbh), .bridge_b_low(bbl),
        .rectifier_a_drive(ra), .rectifier_b_drive(rb), .primary_ss_discharge(pss),
        .rectifier_softstart_node(node), .rectifier_softstart_active(active)
    );

    rect_gate_model PARTNER (
        .ref_clk(ref_clk), .rst(rst), .rectifier_a_drive(ra), .rectifier_b_drive(rb),
        .ground_request(ground_request), .node_forced_low(forced_low),
        .gate_a(), .gate_b()
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) cyc <= cyc + 1;

    task chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task tick;
        @(posedge ref_clk);
        #1;
    endtask

    // One half period; a nonzero fault mask raises hard faults mid-pulse
    task half(input int mode, input logic [4:0] fm);
        logic [3:0] pair;
        logic       in_r, out_r;
        int         w;
        pair = half_a ? 4'h9 : 4'h6;
        w = (cyc - rel - 1024) / 16;
        for (int i = 0; i < PER; i++) begin
            osc_pulse = (i == 0);
            pwm_stop = (i == ON);
            if (fm != 5'h00 && i == ON - 10) hard = fm;
            tick();
            in_r = half_a ? ra : rb;
            out_r = half_a ? rb : ra;
            if (fm != 5'h00) begin
                if (i == ON - 8) chk("drives under fault", {bah, bal, bbh, bbl, ra, rb, pss}, 7'h01);
            end else begin
                if (i == LEAD) chk("bridges in lead", {bah, bal, bbh, bbl}, 4'h0);
                if (i == LEAD + 1) chk("bridge diagonal", {bah, bal, bbh, bbl}, pair);
                if (i == ON + 1) chk("bridges after stop", {bah, bal, bbh, bbl}, 4'h0);
                if (mode == 0) chk("rectifiers held off", {ra, rb}, 2'b00);
                if (mode != 3 && i == 1) chk("soft-start active", active, mode == 1);
                if (mode == 1 && w >= 4 && i == 0) chk("edge keeps in-phase", {in_r, out_r}, 2'b10);
                if (mode == 2 && i == 2) chk("out-of-phase early drop", {in_r, out_r}, 2'b10);
                if ((mode == 1 || mode == 2) && i == LEAD + 1) chk("power rectifiers", {in_r, out_r}, 2'b10);
                if (mode == 2 && i == ON + TRAIL) chk("trail dead-time", out_r, 1'b0);
                if (mode == 2 && i == ON + TRAIL + 2) chk("freewheel both on", {ra, rb}, 2'b11);
                if (mode == 1 && w < 60 && i == ON + 1) chk("in-phase ends", in_r, 1'b0);
                if (mode == 1 && w < 60 && i == ON + TRAIL + 2) chk("pulse still narrow", ra & rb, 1'b0);
                if (mode == 1 && w >= 4 && i == PER - 2) chk("soft-start pulse", {ra, rb}, 2'b11);
            end
        end
        osc_pulse = 1'b0;
        pwm_stop = 1'b0;
        half_a = !half_a;
    endtask

    // Release the node and run half periods, predicting the ramp position
    task ramp(input int nh);
        int n0;
        int mode;
        ss_above_2v = 1'b1;
        comp_current_low = 1'b1;
        rel = cyc;
        for (int h = 0; h < nh; h++) begin
            n0 = cyc - rel;
            if (n0 < 4080) chk("node charge", node <= n0 && node + 4 >= n0, 1'b1);
            if (n0 + PER < 1008) mode = 0;
            else if (n0 > 1088 && n0 + PER < 4064) mode = 1;
            else if (n0 > 4096) mode = 2;
            else mode = 3;
            half(mode, 5'h00);
        end
        $display("test ramp done");
    endtask

    // Slow stop from full node; slope per cycle equals the step
    task soft_stop(input int rate, input logic hic);
        logic [11:0] n0, last;
        int          k;
        if (hic) hiccup_request = 1'b1;
        else line_standby = 1'b1;
        repeat (4) tick();
        n0 = node;
        repeat (20) tick();
        chk("soft-stop slope", n0 - node, 12'(rate * 20));
        k = 0;
        last = node;
        while (pss !== 1'b1 && k < 2000) begin
            last = node;
            tick();
            k++;
        end
        chk("primary held till 1 V", last <= 12'h406 && last >= 12'h3f0, 1'b1);
        repeat (3) tick();
        chk("node discharged", node, 12'h000);
        line_standby = 1'b0;
        hiccup_request = 1'b0;
        ss_above_2v = 1'b0;
        tick();
        $display("test soft stop done");
    endtask

    initial begin
        fails = 0;
        num_checks = 0;
        cyc = 0;
        rel = 0;
        half_a = 1'b1;
        rst = 1'b1;
        {osc_pulse, pwm_stop, ss_above_2v, comp_current_low} = 4'h0;
        {line_standby, hiccup_request, soft_stop_disable, ground_request} = 4'h0;
        hard = 5'h00;
        repeat (4) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("reset drives", {bah, bal, bbh, bbl, ra, rb, pss}, 7'h01);
        chk("reset node", node, 12'h000);
        ss_above_2v = 1'b1;
        repeat (2) half(0, 5'h00);
        ss_above_2v = 1'b0;
        comp_current_low = 1'b1;
        repeat (2) half(0, 5'h00);
        chk("node held without release", node, 12'h000);
        ss_above_2v = 1'b1;
        ground_request = 1'b1;
        repeat (2) half(0, 5'h00);
        chk("node held while grounded", node, 12'h000);
        ground_request = 1'b0;
        $display("test release gating done");
        ramp(23);
        soft_stop(3, 1'b0);
        ramp(23);
        soft_stop(6, 1'b1);
        ramp(23);
        // Disable soft-stop: hiccup must now stop at once
        soft_stop_disable = 1'b1;
        hiccup_request = 1'b1;
        repeat (2) tick();
        chk("hard-stop drives", {bah, bal, bbh, bbl, ra, rb}, 6'h00);
        repeat (3) tick();
        chk("hard-stop node", node, 12'h000);
        hiccup_request = 1'b0;
        soft_stop_disable = 1'b0;
        ss_above_2v = 1'b0;
        $display("test stop disable done");
        for (int f = 0; f < 5; f++) begin
            ss_above_2v = 1'b1;
            half(3, 5'(1 << f));
            ss_above_2v = 1'b0;
            hard = 5'h00;
            half(0, 5'h00);
            chk("fault node discharged", node, 12'h000);
        end
        $display("test hard faults done");
        give_verdict();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        $display("Error watchdog expected finish seen timeout");
        give_verdict();
    end
endmodule
